// [hw/sts_top.sv]
// torque-off and monitored controlled stop with an axi4-lite register slave
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module sts_top
   import sts_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // safety pins and run command, asynchronous
   input wire logic i_sto_n,
   input wire logic i_safety_input_a_n,
   input wire logic i_safety_input_b_n,
   input wire logic i_safety_input_c_n,
   input wire logic i_safety_input_d_n,
   input wire logic i_stop_req_n,
   input wire logic i_run_cmd,
   // measured stator frequency, 0.1 Hz per lsb, same clock
   input wire logic [FREQ_W-1:0] i_stator_freq,
   // power stage and status
   output logic o_pwr_enable,
   output logic o_sto_active,
   output logic o_ss1_active,
   output logic o_fault,
   output logic o_irq,
   // axi4-lite write channels
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // axi4-lite read channels
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   localparam int TCW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      sts_state_t state;
      logic pair_ab_en;
      logic pair_cd_en;
      logic sw_stop;
      logic [1:0] ramp_scale;
      logic [FREQ_W-1:0] ramp_value;
      logic [FREQ_W-1:0] trip_level;
      logic [FREQ_W-1:0] still_level;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic fault;
      logic [7:0] err_code;
      logic run_prev;
      logic [FREQ_W-1:0] f0;
      logic [DROP_W-1:0] drop;
      logic [TCW-1:0] tick_cnt;
      logic aw_hold;
      logic [ADDR_W-1:0] awaddr;
      logic w_hold;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic pwr_en;
      logic sto_act;
      logic ss1_act;
      logic irq;
   } sts_regs_t;

   localparam sts_regs_t REGS_RST = '{
      state: ST_IDLE,
      pair_ab_en: CTRL_AB_RST,
      pair_cd_en: CTRL_CD_RST,
      ramp_scale: RAMP_SCALE_RST,
      ramp_value: RAMP_VALUE_RST,
      trip_level: TRIP_RST,
      still_level: STILL_RST,
      irq_mask: IRQ_MASK_RST,
      err_code: ERR_NONE,
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      default: '0
   };

   sts_regs_t s_q, s_d;

   // ----------------------------------------------------------------
   // register readback, shared by read and write-merge paths
   // ----------------------------------------------------------------
   function automatic logic [32:0] reg_word(input logic [ADDR_W-1:0] a, input sts_regs_t r);
      logic [31:0] w;
      logic hit;
      w = '0;
      hit = 1'b1;
      case (a)
         REG_CTRL: begin
            w[CTRL_AB_BIT] = r.pair_ab_en;
            w[CTRL_CD_BIT] = r.pair_cd_en;
            w[CTRL_SW_STOP_BIT] = r.sw_stop;
         end
         REG_RAMP: begin
            w[RAMP_SCALE_LSB +: 2] = r.ramp_scale;
            w[RAMP_VALUE_LSB +: FREQ_W] = r.ramp_value;
         end
         REG_TRIP: w[FREQ_W-1:0] = r.trip_level;
         REG_STILL: w[FREQ_W-1:0] = r.still_level;
         REG_STATUS: begin
            w[STAT_STO_BIT] = r.sto_act;
            w[STAT_SS1_BIT] = r.ss1_act;
            w[STAT_FAULT_BIT] = r.fault;
            w[STAT_PWR_BIT] = r.pwr_en;
            w[STAT_STATE_LSB +: 2] = r.state;
         end
         REG_IRQ_STAT: w[IRQ_W-1:0] = r.irq_stat;
         REG_IRQ_MASK: w[IRQ_W-1:0] = r.irq_mask;
         REG_ERR: w[7:0] = r.err_code;
         default: hit = 1'b0;
      endcase
      return {hit, w};
   endfunction : reg_word

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pins;

   sts_sync #(
      .W(PIN_W)
   ) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_pins({i_run_cmd, i_stop_req_n, i_safety_input_d_n, i_safety_input_c_n,
               i_safety_input_b_n, i_safety_input_a_n, i_sto_n}),
      .o_pins(pins)
   );

   // ----------------------------------------------------------------
   // request decode and monitoring arithmetic
   // ----------------------------------------------------------------
   logic sto_pin_req, pair_req, sto_any, stop_req, run_in, run_rise, tick, viol, still;
   logic [RATE_W-1:0] rate;
   logic [DROP_W:0] drop_sum, limit_milli, cur_milli;

   assign sto_pin_req = !pins[0]; // fixed, no enable bit
   assign pair_req = (s_q.pair_ab_en && (!pins[1] || !pins[2]))
                   || (s_q.pair_cd_en && (!pins[3] || !pins[4]));
   assign sto_any = sto_pin_req || pair_req;
   assign stop_req = !pins[5] || s_q.sw_stop;
   assign run_in = pins[6];
   assign run_rise = run_in && !s_q.run_prev;
   assign tick = s_q.tick_cnt == TCW'(TICK_CYCLES - 1);
   // ramp in 0.1 Hz/s = scale times value in 0.1 steps
   assign rate = {16'h0000, scale_mult(s_q.ramp_scale)} * {7'h00, s_q.ramp_value};
   assign drop_sum = {1'b0, s_q.drop} + (DROP_W + 1)'(rate);
   // limit scaled by ticks per second so no divide is needed
   assign limit_milli = (DROP_W + 1)'({1'b0, s_q.f0} + {1'b0, s_q.trip_level}) * TICKS_PER_S_W;
   assign cur_milli = (DROP_W + 1)'(i_stator_freq) * TICKS_PER_S_W + {1'b0, s_q.drop};
   assign viol = (s_q.state == ST_STOP) && (cur_milli > limit_milli);
   assign still = i_stator_freq <= s_q.still_level;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [32:0] rw;
      logic [31:0] m;
      logic [31:0] merged;
      logic [IRQ_W-1:0] irq_set;
      logic [IRQ_W-1:0] irq_clr;
      rw = '0;
      m = '0;
      merged = '0;
      irq_set = '0;
      irq_clr = '0;
      s_d = s_q;

      // read channel: one cycle from address to data
      if (s_q.rvalid && i_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (i_arvalid && s_q.arready) begin
         rw = reg_word(i_araddr, s_q);
         s_d.rvalid = 1'b1;
         s_d.rdata = rw[31:0];
         s_d.rresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
      end
      s_d.arready = !s_d.rvalid;

      // write channel: address and data captured in either order
      if (s_q.bvalid && i_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (i_awvalid && s_q.awready) begin
         s_d.aw_hold = 1'b1;
         s_d.awaddr = i_awaddr;
      end
      if (i_wvalid && s_q.wready) begin
         s_d.w_hold = 1'b1;
         s_d.wdata = i_wdata;
         s_d.wstrb = i_wstrb;
      end
      if (s_q.aw_hold && s_q.w_hold) begin
         rw = reg_word(s_q.awaddr, s_q);
         m = strb_mask(s_q.wstrb);
         merged = (rw[31:0] & ~m) | (s_q.wdata & m);
         s_d.aw_hold = 1'b0;
         s_d.w_hold = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = rw[32] ? RESP_OKAY : RESP_SLVERR;
         case (s_q.awaddr)
            REG_CTRL: begin
               s_d.pair_ab_en = merged[CTRL_AB_BIT];
               s_d.pair_cd_en = merged[CTRL_CD_BIT];
               s_d.sw_stop = merged[CTRL_SW_STOP_BIT];
               if (merged[CTRL_FAULT_CLR_BIT]) begin
                  s_d.fault = 1'b0;
                  s_d.err_code = ERR_NONE;
               end
            end
            REG_RAMP: begin
               s_d.ramp_scale = merged[RAMP_SCALE_LSB +: 2];
               s_d.ramp_value = merged[RAMP_VALUE_LSB +: FREQ_W];
            end
            REG_TRIP: s_d.trip_level = merged[FREQ_W-1:0];
            REG_STILL: s_d.still_level = merged[FREQ_W-1:0];
            REG_IRQ_STAT: irq_clr = s_q.wdata[IRQ_W-1:0] & m[IRQ_W-1:0];
            REG_IRQ_MASK: s_d.irq_mask = merged[IRQ_W-1:0];
            default: ;
         endcase
      end
      s_d.awready = !s_d.aw_hold && !s_d.bvalid;
      s_d.wready = !s_d.w_hold && !s_d.bvalid;

      // drive sequencing
      s_d.run_prev = run_in;
      s_d.tick_cnt = tick ? '0 : TCW'(s_q.tick_cnt + 1'b1);
      unique case (s_q.state)
         ST_IDLE: begin
            // only a fresh run edge starts the motor
            if (run_rise && !stop_req) begin
               s_d.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_req) begin
               s_d.state = ST_STOP;
               s_d.f0 = i_stator_freq;
               s_d.drop = '0;
               s_d.tick_cnt = '0;
               irq_set[IRQ_SS1_BIT] = 1'b1;
            end else if (!run_in) begin
               s_d.state = ST_IDLE;
            end
         end
         ST_STOP: begin
            // run and request level ignored until standstill
            if (tick) begin
               s_d.drop = drop_sum[DROP_W] ? '1 : drop_sum[DROP_W-1:0];
            end
            if (viol) begin
               s_d.state = ST_TORQUE_OFF;
               s_d.fault = 1'b1;
               s_d.err_code = ERR_SAFETY_FAULT;
               irq_set[IRQ_FAULT_BIT] = 1'b1;
            end else if (still) begin
               s_d.state = ST_TORQUE_OFF;
            end
         end
         ST_TORQUE_OFF: begin
            if (!sto_any && !s_q.fault) begin
               s_d.state = ST_IDLE;
            end
         end
      endcase
      // torque-off outranks the controlled stop and everything else
      if (sto_any) begin
         s_d.state = ST_TORQUE_OFF;
      end
      if (s_d.state == ST_TORQUE_OFF && s_q.state != ST_TORQUE_OFF) begin
         irq_set[IRQ_STO_BIT] = 1'b1;
      end

      // sticky events; a new event beats a clear in the same cycle
      s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
      // power stage only while running or ramping down
      s_d.pwr_en = (s_d.state == ST_RUN) || (s_d.state == ST_STOP);
      s_d.sto_act = s_d.state == ST_TORQUE_OFF;
      s_d.ss1_act = s_d.state == ST_STOP;
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= REGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign o_pwr_enable = s_q.pwr_en;
   assign o_sto_active = s_q.sto_act;
   assign o_ss1_active = s_q.ss1_act;
   assign o_fault = s_q.fault;
   assign o_irq = s_q.irq;
   assign o_awready = s_q.awready;
   assign o_wready = s_q.wready;
   assign o_bvalid = s_q.bvalid;
   assign o_bresp = s_q.bresp;
   assign o_arready = s_q.arready;
   assign o_rvalid = s_q.rvalid;
   assign o_rdata = s_q.rdata;
   assign o_rresp = s_q.rresp;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_stop_quiet;
      s_q.state == ST_STOP && !sto_any && !viol && !still;
   endsequence

   sequence s_stop_trip;
      s_q.state == ST_STOP && viol;
   endsequence
   sequence s_stop_still;
      s_q.state == ST_STOP && still && !viol;
   endsequence

   a_sto_pin_off: assert property (!i_sys_rst && sto_pin_req
                                   |=> o_sto_active && !o_pwr_enable)
      else $error("torque-off pin did not remove power");
   a_pair_off: assert property (pair_req ##1 pair_req |-> !o_pwr_enable)
      else $error("paired inputs did not remove power");
   a_sto_no_power: assert property (o_sto_active |-> !o_pwr_enable)
      else $error("power enabled during torque-off");
   a_restart_edge: assert property ($rose(o_pwr_enable) |-> $past(run_rise))
      else $error("power enabled without a fresh run edge");
   a_stop_holds: assert property (s_stop_quiet |=> o_ss1_active && o_pwr_enable)
      else $error("controlled stop left before standstill");
   a_trip_fault: assert property (s_stop_trip |=> o_fault && o_sto_active
                                  && s_q.err_code == ERR_SAFETY_FAULT)
      else $error("limit violation did not fault");
   a_still_off: assert property (s_stop_still |=> o_sto_active
                                 && (o_fault == $past(o_fault)))
      else $error("standstill did not enter torque-off cleanly");
   a_entry_capture: assert property ($rose(o_ss1_active) |-> s_q.f0 == $past(i_stator_freq)
                                     && s_q.drop == '0)
      else $error("stop start frequency not captured");
   a_ramp_step: assert property (s_stop_quiet ##0 tick ##0 !drop_sum[DROP_W]
                                 |=> s_q.drop - $past(s_q.drop) == DROP_W'($past(rate)))
      else $error("ramp drop did not advance by the ramp rate");
endmodule : sts_top

// [hw/sts_pkg.sv]
package sts_pkg;
   // ----------------------------------------------------------------
   // Functional notes
   // - The dedicated torque-off pin always requests torque-off; not configurable.
   // - Two paired safety input channels may also request torque-off.
   // - In torque-off the power stage is disabled; control logic keeps running.
   // - After torque-off the motor never restarts without a fresh run edge.
   // - A started controlled stop overrides everything except torque-off.
   // - Ramp scale selects 1, 10 or 100 Hz/s.
   // - Ramp value has 0.1 resolution; ramp equals scale times value.
   // - During controlled stop, speed is checked against ramp limit plus trip threshold.
   // - Exceeding the limit raises the safety fault code and forces torque-off.
   // - Reaching the standstill level during controlled stop forces torque-off.
   // - Controlled stop stays active to standstill even if the request goes away.
   // - Fault and standstill checks use the measured stator frequency.
   // - After a controlled stop a new run edge is needed; the source issues it.
   // ----------------------------------------------------------------

   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int FREQ_W = 16;
   localparam int DROP_W = 40;
   localparam int RATE_W = 23;
   localparam int ADDR_W = 8;
   localparam int IRQ_W = 3;
   localparam int PIN_W = 7;
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES_DEF = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
   localparam int TICKS_PER_S = 1_000_000 / TICK_TIME_US;
   localparam logic [DROP_W:0] TICKS_PER_S_W = (DROP_W + 1)'(TICKS_PER_S);

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] REG_RAMP = 8'h04;
   localparam logic [ADDR_W-1:0] REG_TRIP = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STILL = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h18;
   localparam logic [ADDR_W-1:0] REG_ERR = 8'h1C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_AB_BIT = 0;
   localparam int CTRL_CD_BIT = 1;
   localparam int CTRL_SW_STOP_BIT = 2;
   localparam int CTRL_FAULT_CLR_BIT = 3;
   localparam int RAMP_SCALE_LSB = 0;
   localparam int RAMP_VALUE_LSB = 16;
   localparam int STAT_STO_BIT = 0;
   localparam int STAT_SS1_BIT = 1;
   localparam int STAT_FAULT_BIT = 2;
   localparam int STAT_PWR_BIT = 3;
   localparam int STAT_STATE_LSB = 4;
   localparam int IRQ_STO_BIT = 0;
   localparam int IRQ_SS1_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic CTRL_AB_RST = 1'b1;
   localparam logic CTRL_CD_RST = 1'b1;
   localparam logic [1:0] RAMP_SCALE_RST = 2'h1;
   localparam logic [FREQ_W-1:0] RAMP_VALUE_RST = 16'h0032;
   localparam logic [FREQ_W-1:0] TRIP_RST = 16'h0064;
   localparam logic [FREQ_W-1:0] STILL_RST = 16'h000A;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_SAFETY_FAULT = 8'h5A;
   localparam logic [1:0] SCALE_1 = 2'h0;
   localparam logic [1:0] SCALE_10 = 2'h1;
   localparam logic [6:0] MULT_1 = 7'h01;
   localparam logic [6:0] MULT_10 = 7'h0A;
   localparam logic [6:0] MULT_100 = 7'h64;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // drive states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_STOP = 2'b10,
      ST_TORQUE_OFF = 2'b11
   } sts_state_t;

   // ramp scale code to multiplier; the spare code takes the steepest ramp
   function automatic logic [6:0] scale_mult(input logic [1:0] code);
      logic [6:0] m;
      m = MULT_100;
      if (code == SCALE_1) begin
         m = MULT_1;
      end else if (code == SCALE_10) begin
         m = MULT_10;
      end
      return m;
   endfunction : scale_mult

   // byte strobes to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction : strb_mask
endpackage : sts_pkg

// [hw/sts_sync.sv]
// three-stage pin synchroniser; output moves once stages two and three agree
module sts_sync
   import sts_pkg::*;
#(
   parameter int W = PIN_W
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // raw pins and filtered levels
   input wire logic [W-1:0] i_pins,
   output logic [W-1:0] o_pins
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sts_sync_regs_t;

   sts_sync_regs_t s_q, s_d;

   // shift chain and agreement filter
   always_comb begin
      s_d = s_q;
      s_d.s1 = i_pins;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < W; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.lvl[i] = s_q.s3[i];
         end
      end
   end

   // zero at reset reads as every safety pin demanding a stop
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pins = s_q.lvl;
endmodule : sts_sync

// [tb/sts_plant.sv]
module sts_plant
   import sts_pkg::*;
(
   // clock and drive state
   input wire logic i_clk,
   input wire logic i_pwr,
   input wire logic i_ss1,
   // set point and stop slope per cycle
   input wire logic [FREQ_W-1:0] i_target,
   input wire logic [FREQ_W-1:0] i_step,
   // measured stator frequency
   output logic [FREQ_W-1:0] o_freq = '0
);
   timeunit 1ns;
   timeprecision 1ps;
   // motor coasts without torque, follows the stop slope, else climbs to set point
   always @(posedge i_clk) begin
      if (!i_pwr) begin
         o_freq <= (o_freq != '0) ? o_freq - 16'h0001 : '0;
      end else if (i_ss1) begin
         o_freq <= (o_freq > i_step) ? o_freq - i_step : '0;
      end else if (o_freq < i_target) begin
         o_freq <= o_freq + 16'h0001;
      end
   end
endmodule : sts_plant

// [tb/test_safe_torque_off_and_safe_stop.sv]
module test_safe_torque_off_and_safe_stop
   import sts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TCK = 10;
   logic i_clk = 1'h0;
   logic i_sys_rst = 1'h1;
   logic [4:0] req_n = 5'h1F; // torque-off pin, then inputs a to d
   logic i_stop_req_n = 1'h1;
   logic i_run_cmd = 1'h0;
   logic [FREQ_W-1:0] i_stator_freq, target = 16'h0190, step = 16'h0002;
   logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
   logic [31:0] i_wdata = '0, o_rdata;
   logic [3:0] i_wstrb = 4'hF;
   logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   logic o_pwr_enable, o_sto_active, o_ss1_active, o_fault, o_irq;
   logic [33:0] exp_q[$];
   int err_count = 0, checks = 0;
   sts_top #(.TICK_CYCLES(TCK)) u_sts_top (
      .i_clk, .i_sys_rst, .i_sto_n(req_n[0]), .i_safety_input_a_n(req_n[1]),
      .i_safety_input_b_n(req_n[2]), .i_safety_input_c_n(req_n[3]),
      .i_safety_input_d_n(req_n[4]), .i_stop_req_n, .i_run_cmd, .i_stator_freq,
      .o_pwr_enable, .o_sto_active, .o_ss1_active, .o_fault, .o_irq, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
   sts_plant u_sts_plant (.i_clk, .i_pwr(o_pwr_enable), .i_ss1(o_ss1_active),
      .i_target(target), .i_step(step), .o_freq(i_stator_freq));
   // clock
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   // bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      i_bready <= 1'h1;
      do begin
         @(posedge i_clk);
         if (o_awready) i_awvalid <= 1'h0;
         if (o_wready) i_wvalid <= 1'h0;
      end while (!o_bvalid);
      chk("bresp", RESP_OKAY, o_bresp);
      i_bready <= 1'h0;
      @(posedge i_clk);
   endtask : wr
   // bus read: the expected word is queued for the watcher
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_q.push_back({r, d});
      i_araddr <= a;
      i_arvalid <= 1'h1;
      i_rready <= 1'h1;
      do begin
         @(posedge i_clk);
         if (o_arready) i_arvalid <= 1'h0;
      end while (!o_rvalid);
      i_rready <= 1'h0;
      @(posedge i_clk);
   endtask : rd
   // read watcher takes the oldest note at each read handshake
   always @(posedge i_clk) begin
      if (o_rvalid && i_rready) chk("read", exp_q.pop_front(), {o_rresp, o_rdata});
   end
   // fresh run edge, then wait for the motor to reach its set point
   task automatic go_run();
      i_run_cmd <= 1'h0;
      cyc(4);
      i_run_cmd <= 1'h1;
      cyc(760);
      chk("pwr", 1, o_pwr_enable);
   endtask : go_run
   task automatic tally_and_finish();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // watchdog
   initial begin
      cyc(90000);
      err_count++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      int f, k, v;
      void'($urandom(99345));
      cyc(5);
      i_sys_rst <= 1'h0;
      cyc(10);
      chk("pwr", 0, o_pwr_enable);
      rd(REG_CTRL, 32'h0000_0003, RESP_OKAY);
      rd(REG_RAMP, 32'h0032_0001, RESP_OKAY);
      rd(REG_STILL, 32'h0000_000A, RESP_OKAY);
      rd(8'h20, 32'h0000_0000, RESP_SLVERR);
      wr(REG_IRQ_STAT, 32'h0000_0007);
      rd(REG_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
      target <= 16'(300 + $urandom % 400);
      // every torque-off source removes power and release never restarts
      for (int i = 0; i < 5; i++) begin
         go_run();
         req_n[i] <= 1'h0;
         cyc(8);
         chk("sto", 1, o_sto_active);
         chk("pwr", 0, o_pwr_enable);
         req_n[i] <= 1'h1;
         cyc(8);
         chk("pwr", 0, o_pwr_enable);
      end
      wr(REG_IRQ_MASK, 32'h0000_0007);
      chk("irq", 1, o_irq);
      wr(REG_IRQ_STAT, 32'h0000_0007);
      chk("irq", 0, o_irq);
      // disabled pair is ignored
      wr(REG_CTRL, 32'h0000_0002);
      go_run();
      req_n[1] <= 1'h0;
      cyc(8);
      chk("pwr", 1, o_pwr_enable);
      req_n[1] <= 1'h1;
      cyc(8);
      wr(REG_CTRL, 32'h0000_0003);
      // torque-off overrides a running stop
      go_run();
      i_stop_req_n <= 1'h0;
      cyc(8);
      chk("ss1", 1, o_ss1_active);
      req_n[0] <= 1'h0;
      cyc(8);
      chk("ss1", 0, o_ss1_active);
      chk("sto", 1, o_sto_active);
      req_n[0] <= 1'h1;
      i_stop_req_n <= 1'h1;
      // stop request withdrawn early, stop runs on to standstill
      go_run();
      i_stop_req_n <= 1'h0;
      cyc(8);
      i_stop_req_n <= 1'h1;
      cyc(20);
      chk("ss1", 1, o_ss1_active);
      while (!o_sto_active) @(posedge i_clk);
      chk("still", 1, i_stator_freq <= STILL_RST);
      chk("fault", 0, o_fault);
      cyc(8);
      chk("pwr", 0, o_pwr_enable);
      // motor holds speed: trip time follows each ramp scale, spare code by software stop
      step <= 16'h0000;
      for (int s = 0; s < 4; s++) begin
         v = 40 + $urandom % 21;
         k = 100000 / (v * (s == 0 ? 1 : (s == 1 ? 10 : 100))) + 1;
         wr(REG_RAMP, {16'(v), 14'h0000, 2'(s)});
         rd(REG_RAMP, {16'(v), 14'h0000, 2'(s)}, RESP_OKAY);
         go_run();
         if (s == 3) begin
            wr(REG_CTRL, 32'h0000_0007);
         end else begin
            i_stop_req_n <= 1'h0;
         end
         f = 0;
         while (!o_fault) begin
            @(posedge i_clk);
            f++;
         end
         chk("trip", 1, f >= k * TCK - 10 && f <= k * TCK + 25);
         chk("sto", 1, o_sto_active);
         rd(REG_ERR, {24'h00_0000, ERR_SAFETY_FAULT}, RESP_OKAY);
         chk("irq", 1, o_irq);
         i_stop_req_n <= 1'h1;
         wr(REG_CTRL, 32'h0000_000B);
         wr(REG_IRQ_STAT, 32'h0000_0007);
         cyc(4);
         chk("fault", 0, o_fault);
         rd(REG_ERR, 32'h0000_0000, RESP_OKAY);
      end
      tally_and_finish();
   end
endmodule : test_safe_torque_off_and_safe_stop
